// ### rtl/pra_pkg.sv
// pra_pkg: register indices, field positions, reset values and timing constants
// of the phase readout / phase alarm timer block.
// assumes a 10 MHz core clock and an apb slave with 32-bit data.
package pra_pkg;

  // printed register offsets are word indices; byte address is four times the index
  localparam int unsigned ADDR_W        = 12;
  localparam logic [7:0]  IDX_PHASE_LO  = 8'h77;
  localparam logic [7:0]  IDX_PHASE_HI  = 8'h78;
  localparam logic [7:0]  IDX_ALM_DELAY = 8'h79;
  localparam logic [7:0]  IDX_CTRL      = 8'h7b;
  localparam logic [7:0]  IDX_INT_STS   = 8'h7c;
  localparam logic [7:0]  IDX_INT_MASK  = 8'h7d;
  localparam logic [7:0]  IDX_ALM_STS   = 8'h7e;

  // reset values
  localparam logic [7:0]  RST_PHASE     = 8'h00;
  localparam logic [7:0]  RST_ALM_DELAY = 8'h32;
  localparam logic [1:0]  RST_CTRL      = 2'h0;
  localparam logic [1:0]  RST_INT       = 2'h0;

  // field positions
  localparam int unsigned DELAY_W       = 6;
  localparam int unsigned CTRL_SRC_BIT  = 0;
  localparam int unsigned CTRL_AUTO_BIT = 1;
  localparam int unsigned INT_ALM_BIT   = 0;
  localparam int unsigned INT_UPD_BIT   = 1;
  localparam int unsigned ALM_BIT       = 0;

  // timing
  localparam longint unsigned CLK_HZ       = 64'd10_000_000;
  localparam longint unsigned ALM_UNIT_S   = 64'd2;
  localparam longint unsigned UNIT_CYCLES  = ALM_UNIT_S * CLK_HZ;
  localparam int unsigned     AVG_SHIFT    = 3;

endpackage

// ### rtl/pra_avg_if.sv
// pra_avg_if: carries selected phase samples into the averager and the mean back out.
// assumes one clock shared by both ends.
`timescale 1ns/100ps
interface pra_avg_if;
  logic        restart;
  logic        in_valid;
  logic [15:0] in_phase;
  logic        out_valid;
  logic [15:0] out_avg;

  modport src (output restart, output in_valid, output in_phase,
               input out_valid, input out_avg);
  modport avg (input restart, input in_valid, input in_phase,
               output out_valid, output out_avg);
endinterface

// ### rtl/pra_phase_avg.sv
// pra_phase_avg: running exponential mean of signed 16-bit phase samples.
// assumes samples arrive as single-cycle valid strobes on the shared clock.
`timescale 1ns/100ps
module pra_phase_avg
  import pra_pkg::*;
#(
  parameter int unsigned SHIFT = AVG_SHIFT
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // averaging port
  pra_avg_if.avg    av
);

  logic signed [17:0] acc_q;
  logic signed [17:0] diff;
  logic signed [17:0] acc_d;
  logic               vld_q;

  // two guard bits keep the difference of two full-scale values from wrapping
  always_comb begin
    diff  = 18'(signed'(av.in_phase)) - acc_q;
    acc_d = acc_q + (diff >>> SHIFT);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
    end else if (av.restart) begin
      acc_q <= '0;
    end else if (av.in_valid) begin
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vld_q <= 1'b0;
    end else begin
      vld_q <= av.in_valid & ~av.restart;
    end
  end

  assign av.out_avg   = acc_q[15:0];
  assign av.out_valid = vld_q;

  property p_avg_step;
    @(posedge clk) disable iff (!rst_n)
      (av.in_valid && !av.restart) |=> (vld_q && acc_q == $past(acc_d));
  endproperty
  a_avg_step: assert property (p_avg_step) else $error("average step wrong");

endmodule

// ### rtl/pra_phase_alarm_top.sv
// pra_phase_alarm_top: averaged phase readout and phase alarm delay timer behind apb.
// assumes phase samples from both plls and the alarm condition are synchronous to clk.
// Function
// - low byte of averaged phase reads back read-only, reset zero
// - high byte reads separately, reset zero; both form one 16-bit value
// - phase taken from first or second pll as pll_source_select picks
// - phase value averaged before it is offered for readback
// - configurable timeout before alarm is raised; reset value 0x32
// - raised alarm persists until software clear or timeout clear
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
module pra_phase_alarm_top
  import pra_pkg::*;
#(
  parameter longint unsigned UNIT_CYC = UNIT_CYCLES
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // phase detectors
  input  wire logic [15:0]       first_digital_pll_phase,
  input  wire logic              first_digital_pll_valid,
  input  wire logic [15:0]       second_digital_pll_phase,
  input  wire logic              second_digital_pll_valid,
  // alarm
  input  wire logic              phase_alarm_cond,
  output logic                   phase_alarm,
  output logic                   irq
);

  localparam int unsigned UCNT_W = $clog2(UNIT_CYC + 1);
  localparam logic [UCNT_W-1:0] UNIT_LAST = UCNT_W'(UNIT_CYC - 1);

  pra_avg_if av_if ();

  logic [31:0]        prdata_q;
  logic               pready_q;
  logic               pslverr_q;
  logic               irq_q;
  logic [1:0]         ctrl_q;
  logic [7:0]         delay_q;
  logic [1:0]         int_sts_q;
  logic [1:0]         int_mask_q;
  logic               alarm_q;
  logic [7:0]         hi_snap_q;
  logic               sel_last_q;
  logic               smp_vld_q;
  logic [15:0]        smp_q;
  logic [UCNT_W-1:0]  ucnt_q;
  logic [DELAY_W-1:0] units_q;

  logic               acc_cyc;
  logic               wr_en;
  logic               rd_en;
  logic [7:0]         idx;
  logic               idx_ok;
  logic               counting;
  logic               unit_tick;
  logic               target_hit;
  logic               alarm_set;
  logic               alarm_auto_clr;
  logic               alarm_sw_clr;
  logic [31:0]        rd_word;

  // register index decode; a misaligned or out-of-map address is refused
  function automatic logic idx_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    return (a[1:0] == 2'h0) && (a[ADDR_W-1:10] == '0) &&
           (i == IDX_PHASE_LO || i == IDX_PHASE_HI || i == IDX_ALM_DELAY ||
            i == IDX_CTRL || i == IDX_INT_STS || i == IDX_INT_MASK || i == IDX_ALM_STS);
  endfunction

  // one wait state: pready rises on the second access cycle, from a flop;
  // a write lands only at the edge where the master sees pready high
  assign acc_cyc = psel & penable & ~pready_q;
  assign idx     = paddr[9:2];
  assign idx_ok  = idx_mapped(paddr);
  assign wr_en   = psel & penable & pready_q & pwrite & idx_ok;
  assign rd_en   = acc_cyc & ~pwrite & idx_ok;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc_cyc;
      pslverr_q <= acc_cyc & ~idx_ok;
    end
  end

  always_comb begin
    rd_word = 32'h0;
    unique case (idx)
      IDX_PHASE_LO:  rd_word[7:0] = av_if.out_avg[7:0];
      IDX_PHASE_HI:  rd_word[7:0] = hi_snap_q;
      IDX_ALM_DELAY: rd_word[7:0] = delay_q;
      IDX_CTRL:      rd_word[1:0] = ctrl_q;
      IDX_INT_STS:   rd_word[1:0] = int_sts_q;
      IDX_INT_MASK:  rd_word[1:0] = int_mask_q;
      IDX_ALM_STS:   rd_word[ALM_BIT] = alarm_q;
      default:       rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0;
    end else if (rd_en) begin
      prdata_q <= rd_word;
    end else if (acc_cyc) begin
      prdata_q <= 32'h0;
    end
  end

  // reading the low byte freezes the high byte so a two-read pair is coherent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_snap_q <= RST_PHASE;
    end else if (rd_en && idx == IDX_PHASE_LO) begin
      hi_snap_q <= av_if.out_avg[15:8];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= RST_CTRL;
    end else if (wr_en && idx == IDX_CTRL) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  // bits 7:6 are not stored and read as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_q <= RST_ALM_DELAY;
    end else if (wr_en && idx == IDX_ALM_DELAY) begin
      delay_q <= {2'h0, pwdata[DELAY_W-1:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_mask_q <= RST_INT;
    end else if (wr_en && idx == IDX_INT_MASK) begin
      int_mask_q <= pwdata[1:0];
    end
  end

  // source mux is registered; a change of source restarts the mean
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      smp_vld_q  <= 1'b0;
      smp_q      <= 16'h0;
      sel_last_q <= 1'b0;
    end else begin
      sel_last_q <= ctrl_q[CTRL_SRC_BIT];
      if (ctrl_q[CTRL_SRC_BIT]) begin
        smp_vld_q <= second_digital_pll_valid;
        smp_q     <= second_digital_pll_phase;
      end else begin
        smp_vld_q <= first_digital_pll_valid;
        smp_q     <= first_digital_pll_phase;
      end
    end
  end

  // signed samples stay two's complement through the mean
  assign av_if.restart  = sel_last_q ^ ctrl_q[CTRL_SRC_BIT];
  assign av_if.in_valid = smp_vld_q;
  assign av_if.in_phase = smp_q;

  pra_phase_avg #(
    .SHIFT (AVG_SHIFT)
  ) u_avg (
    .clk   (clk),
    .rst_n (rst_n),
    .av    (av_if.avg)
  );

  // while armed the timer runs on the condition; once raised it runs only for auto clear
  assign counting   = alarm_q ? ctrl_q[CTRL_AUTO_BIT] : phase_alarm_cond;
  assign unit_tick  = counting && (ucnt_q == UNIT_LAST);
  assign target_hit = counting && (units_q == delay_q[DELAY_W-1:0]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ucnt_q  <= '0;
      units_q <= '0;
    end else if (!counting || target_hit || alarm_set) begin
      ucnt_q  <= '0;
      units_q <= '0;
    end else if (unit_tick) begin
      ucnt_q  <= '0;
      units_q <= units_q + 1'b1;
    end else begin
      ucnt_q  <= ucnt_q + 1'b1;
    end
  end

  assign alarm_set      = !alarm_q && phase_alarm_cond && target_hit;
  assign alarm_auto_clr = alarm_q && ctrl_q[CTRL_AUTO_BIT] && target_hit;
  assign alarm_sw_clr   = wr_en && idx == IDX_ALM_STS && pwdata[ALM_BIT];

  // no self re-qualification: only software or the auto clear drops it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_q <= 1'b0;
    end else if (alarm_set) begin
      alarm_q <= 1'b1;
    end else if (alarm_sw_clr || alarm_auto_clr) begin
      alarm_q <= 1'b0;
    end
  end

  // sticky events, write one to clear; a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_sts_q <= RST_INT;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == INT_ALM_BIT && alarm_set) || (i == INT_UPD_BIT && av_if.out_valid)) begin
          int_sts_q[i] <= 1'b1;
        end else if (wr_en && idx == IDX_INT_STS && pwdata[i]) begin
          int_sts_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(int_sts_q & int_mask_q);
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign irq         = irq_q;
  assign phase_alarm = alarm_q;

  property p_rd_lo;
    @(posedge clk) disable iff (!rst_n)
      (pready_q && !pwrite && !pslverr_q && idx == IDX_PHASE_LO)
        |-> prdata_q == {24'h0, $past(av_if.out_avg[7:0])};
  endproperty
  a_rd_lo: assert property (p_rd_lo) else $error("low phase byte read wrong");

  property p_rd_hi;
    @(posedge clk) disable iff (!rst_n)
      (pready_q && !pwrite && !pslverr_q && idx == IDX_PHASE_HI)
        |-> prdata_q == {24'h0, $past(hi_snap_q)};
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("high phase byte read wrong");

  property p_src;
    @(posedge clk) disable iff (!rst_n)
      ##1 (smp_vld_q == ($past(ctrl_q[CTRL_SRC_BIT]) ? $past(second_digital_pll_valid)
                                                     : $past(first_digital_pll_valid)));
  endproperty
  a_src: assert property (p_src) else $error("phase source mux wrong");

  property p_restart;
    @(posedge clk) disable iff (!rst_n)
      $changed(ctrl_q[CTRL_SRC_BIT]) |=> (av_if.out_avg == 16'h0 && !av_if.out_valid);
  endproperty
  a_restart: assert property (p_restart) else $error("mean not restarted");

  property p_delay_top;
    @(posedge clk) disable iff (!rst_n)
      delay_q[7:6] == 2'h0;
  endproperty
  a_delay_top: assert property (p_delay_top) else $error("unused delay bits set");

  property p_raise;
    @(posedge clk) disable iff (!rst_n)
      $rose(alarm_q) |-> ($past(phase_alarm_cond) &&
                          $past(units_q) == $past(delay_q[DELAY_W-1:0]));
  endproperty
  a_raise: assert property (p_raise) else $error("alarm raised early");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      (alarm_q && !alarm_sw_clr && !alarm_auto_clr) |=> alarm_q;
  endproperty
  a_hold: assert property (p_hold) else $error("alarm dropped on its own");

  property p_irq;
    @(posedge clk) disable iff (!rst_n)
      ##1 (irq_q == |($past(int_sts_q) & $past(int_mask_q)));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  property p_ready;
    @(posedge clk) disable iff (!rst_n)
      (psel && penable && !pready_q) |=> pready_q ##1 !pready_q;
  endproperty
  a_ready: assert property (p_ready) else $error("apb ready timing wrong");

  property p_err;
    @(posedge clk) disable iff (!rst_n)
      pslverr_q |-> (pready_q && !idx_mapped(paddr));
  endproperty
  a_err: assert property (p_err) else $error("error on a mapped address");

  property p_wr_lands;
    @(posedge clk) disable iff (!rst_n)
      $changed(int_mask_q) |-> $past(psel && penable && pready_q && pwrite);
  endproperty
  a_wr_lands: assert property (p_wr_lands) else $error("write landed off the completing edge");

  property p_snap;
    @(posedge clk) disable iff (!rst_n)
      $changed(hi_snap_q) |-> $past(rd_en && idx == IDX_PHASE_LO);
  endproperty
  a_snap: assert property (p_snap) else $error("high byte snapshot moved");

  property p_alm_event;
    @(posedge clk) disable iff (!rst_n)
      $rose(alarm_q) |-> int_sts_q[INT_ALM_BIT];
  endproperty
  a_alm_event: assert property (p_alm_event) else $error("alarm event lost");

  property p_drop;
    @(posedge clk) disable iff (!rst_n)
      $fell(alarm_q) |-> $past(alarm_sw_clr || alarm_auto_clr);
  endproperty
  a_drop: assert property (p_drop) else $error("alarm dropped without a clear");

  c_raise: cover property (@(posedge clk) disable iff (!rst_n) $rose(alarm_q));
  c_auto:  cover property (@(posedge clk) disable iff (!rst_n) alarm_auto_clr);
  c_swap:  cover property (@(posedge clk) disable iff (!rst_n) $changed(ctrl_q[CTRL_SRC_BIT]));
  c_rd_lo: cover property (@(posedge clk) disable iff (!rst_n) rd_en && idx == IDX_PHASE_LO);
  c_sw:    cover property (@(posedge clk) disable iff (!rst_n) alarm_sw_clr);

endmodule

// ### bench/test_phase_readout_alarm_timer.sv
// test_phase_readout_alarm_timer: self-checking bench for the phase readout and alarm timer.
// assumes one 10 MHz clock and apb answers noted in a queue that the monitor consumes.
`timescale 1ns/100ps
module test_phase_readout_alarm_timer;
  import pra_pkg::*;
  // shortened two-second unit keeps alarm runs to a few dozen cycles
  localparam longint unsigned UC = 4;
  typedef struct {
    logic        rd;
    logic [31:0] data;
    logic        err;
    string       name;
  } pra_note_t;

  logic              clk;
  logic              rst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [15:0]       p1;
  logic [15:0]       p2;
  logic              v1;
  logic              v2;
  logic              cond;
  logic              phase_alarm;
  logic              irq;
  pra_note_t         notes[$];
  int                n_mismatch;
  int                checked;
  int                cycles;
  logic [31:0]       rng;
  logic [15:0]       avg;
  logic [7:0]        snap;

  pra_phase_alarm_top #(.UNIT_CYC(UC)) dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_digital_pll_phase(p1), .first_digital_pll_valid(v1),
    .second_digital_pll_phase(p2), .second_digital_pll_valid(v2),
    .phase_alarm_cond(cond), .phase_alarm(phase_alarm), .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // the monitor takes the oldest note whenever the slave answers
  always @(posedge clk) begin
    pra_note_t n;
    if (rst_n === 1'b1 && pready === 1'b1) begin
      if (notes.size() == 0) check("unasked answer", 32'h0, 32'h1);
      else begin
        n = notes.pop_front();
        check({n.name, " err"}, {31'h0, n.err}, {31'h0, pslverr});
        if (n.rd) check(n.name, n.data, prdata);
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                     input logic [31:0] exp, input logic err, input string name);
    int w;
    notes.push_back('{~wr, exp, err, name});
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // the wait is open-ended; only the bench timeout ends a hung transfer
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (pready !== 1'b1);
    check("pready wait", 32'h2, 32'(w));
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string name);
    apb(1'b0, {2'b00, idx, 2'b00}, 32'h0, exp, 1'b0, name);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, {2'b00, idx, 2'b00}, d, 32'h0, 1'b0, "write");
  endtask

  // back-to-back samples; the unselected pll strobes a different value at once
  task automatic burst(input logic sel2, input int n);
    logic [15:0]        s;
    logic signed [16:0] d;
    for (int i = 0; i < n; i++) begin
      s = 16'(xs());
      s = {{3{s[12]}}, s[12:0]};
      @(posedge clk);
      p1 <= sel2 ? ~s : s;
      p2 <= sel2 ? s : ~s;
      v1 <= 1'b1;
      v2 <= 1'b1;
      d = $signed({s[15], s}) - $signed({avg[15], avg});
      avg = avg + 16'(d >>> AVG_SHIFT);
    end
    @(posedge clk);
    v1 <= 1'b0;
    v2 <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic wait_alarm(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (phase_alarm !== lvl && n < 100) begin
      @(posedge clk);
      n++;
    end
    checked++;
    if (n < lo || n > hi) begin
      n_mismatch++;
      $display("unexpected alarm delay expected %0d..%0d seen %0d", lo, hi, n);
    end
  endtask

  initial begin
    {rst_n, psel, penable, pwrite, v1, v2, cond} = '0;
    paddr = '0;
    pwdata = '0;
    p1 = '0;
    p2 = '0;
    rng = 32'hff31;
    avg = 16'h0000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    check("alarm at reset", 32'h0, {31'h0, phase_alarm});
    rd(IDX_PHASE_LO, {24'h0, RST_PHASE}, "phase lo");
    rd(IDX_PHASE_HI, {24'h0, RST_PHASE}, "phase hi");
    rd(IDX_ALM_DELAY, {24'h0, RST_ALM_DELAY}, "delay");
    rd(IDX_CTRL, 32'h0, "ctrl");
    rd(IDX_INT_STS, 32'h0, "int sts");
    rd(IDX_INT_MASK, 32'h0, "int mask");
    apb(1'b0, 12'h1e8, 32'h0, 32'h0, 1'b1, "unmapped");
    apb(1'b1, 12'h1dd, 32'h5, 32'h0, 1'b1, "misaligned");
    wr(IDX_PHASE_LO, 32'hffff_ffff);
    rd(IDX_PHASE_LO, 32'h0, "phase lo ro");
    wr(IDX_ALM_DELAY, 32'hffff_ffff);
    rd(IDX_ALM_DELAY, 32'h3f, "delay width");
    wr(IDX_ALM_DELAY, 32'h0000_00c5);
    rd(IDX_ALM_DELAY, 32'h05, "delay upper");
    burst(1'b0, 6);
    rd(IDX_PHASE_LO, {24'h0, avg[7:0]}, "avg lo");
    rd(IDX_PHASE_HI, {24'h0, avg[15:8]}, "avg hi");
    snap = avg[15:8];
    burst(1'b0, 3);
    rd(IDX_PHASE_HI, {24'h0, snap}, "hi snapshot");
    rd(IDX_PHASE_LO, {24'h0, avg[7:0]}, "avg lo");
    rd(IDX_PHASE_HI, {24'h0, avg[15:8]}, "avg hi");
    check("irq masked", 32'h0, {31'h0, irq});
    rd(IDX_INT_STS, 32'h2, "int sts upd");
    wr(IDX_INT_MASK, 32'h2);
    repeat (2) @(posedge clk);
    check("irq upd", 32'h1, {31'h0, irq});
    wr(IDX_INT_STS, 32'h2);
    repeat (2) @(posedge clk);
    check("irq cleared", 32'h0, {31'h0, irq});
    wr(IDX_CTRL, 32'h1);
    avg = 16'h0000;
    burst(1'b1, 5);
    rd(IDX_PHASE_LO, {24'h0, avg[7:0]}, "second lo");
    rd(IDX_PHASE_HI, {24'h0, avg[15:8]}, "second hi");
    wr(IDX_CTRL, 32'h0);
    avg = 16'h0000;
    wr(IDX_INT_STS, 32'h3);
    wr(IDX_INT_MASK, 32'h1);
    wr(IDX_ALM_DELAY, 32'h2);
    // a condition shorter than the timeout must not raise the alarm
    @(posedge clk);
    cond <= 1'b1;
    repeat (6) @(posedge clk);
    cond <= 1'b0;
    repeat (20) @(posedge clk);
    check("short cond", 32'h0, {31'h0, phase_alarm});
    cond <= 1'b1;
    wait_alarm(1'b1, 8, 16);
    cond <= 1'b0;
    repeat (20) @(posedge clk);
    check("alarm held", 32'h1, {31'h0, phase_alarm});
    check("irq alarm", 32'h1, {31'h0, irq});
    rd(IDX_ALM_STS, 32'h1, "alarm sts");
    rd(IDX_INT_STS, 32'h1, "int sts alarm");
    wr(IDX_ALM_STS, 32'h1);
    repeat (2) @(posedge clk);
    check("alarm cleared", 32'h0, {31'h0, phase_alarm});
    wr(IDX_INT_STS, 32'h1);
    repeat (2) @(posedge clk);
    check("irq off", 32'h0, {31'h0, irq});
    wr(IDX_CTRL, 32'h2);
    @(posedge clk);
    cond <= 1'b1;
    wait_alarm(1'b1, 8, 16);
    cond <= 1'b0;
    wait_alarm(1'b0, 4, 30);
    // a second reset in mid-run must bring the delay, high byte and control registers back to their reset values
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(IDX_ALM_DELAY, {24'h0, RST_ALM_DELAY}, "delay again");
    rd(IDX_PHASE_HI, {24'h0, RST_PHASE}, "hi again");
    rd(IDX_CTRL, 32'h0, "ctrl again");
    repeat (4) @(posedge clk);
    complete_run();
  end
endmodule
